// *** src/fir_coeff_pkg.sv ***
// Constants, types and helpers shared by the tap coefficient bank.
// Assumes a 32-bit AHB-Lite bus where byte address = 4 x register index.
package fir_coeff_pkg;

    // ****************************************************************
    // Filter shape
    // ****************************************************************
    localparam int NUM_TAPS     = 9;
    localparam int CENTER_TAP   = 4;
    localparam int EDGE_TAPS    = 8;
    localparam int COEFF_WIDTH  = 12;
    localparam int CENTER_WIDTH = 18;
    localparam int REG_WIDTH    = 16;
    localparam int COEFF_MSB    = 11;
    localparam int RESV_LSB     = 12;

    // ****************************************************************
    // Register map (indices; byte address is four times the index)
    // ****************************************************************
    localparam int ADDR_WIDTH = 14;
    localparam int NUM_REGS   = 6;
    localparam logic [11:0] IDX_CHAN_A_TAP6 = 12'h423;
    localparam logic [11:0] IDX_CHAN_A_TAP7 = 12'h425;
    localparam logic [11:0] IDX_CHAN_A_TAP8 = 12'h427;
    localparam logic [11:0] IDX_CHAN_A_TAP9 = 12'h429;
    localparam logic [11:0] IDX_CHAN_B_TAP1 = 12'h448;
    localparam logic [11:0] IDX_CHAN_B_TAP2 = 12'h44a;
    localparam logic [2:0]  SLOT_CHAN_A_TAP6 = 3'h0;
    localparam logic [2:0]  SLOT_CHAN_A_TAP7 = 3'h1;
    localparam logic [2:0]  SLOT_CHAN_A_TAP8 = 3'h2;
    localparam logic [2:0]  SLOT_CHAN_A_TAP9 = 3'h3;
    localparam logic [2:0]  SLOT_CHAN_B_TAP1 = 3'h4;
    localparam logic [2:0]  SLOT_CHAN_B_TAP2 = 3'h5;
    localparam logic [15:0] TAP_RESET        = 16'h0000;
    localparam logic [17:0] WIDE_RESET       = 18'h0_0000;

    // ****************************************************************
    // Bus encodings
    // ****************************************************************
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef logic        [COEFF_WIDTH-1:0]  coeff_type;
    typedef logic signed [CENTER_WIDTH-1:0] wide_coeff_type;

    // Widens a 12-bit two's complement tap to the center tap width
    function automatic wide_coeff_type widen(input coeff_type c);
        widen = {{(CENTER_WIDTH - COEFF_WIDTH){c[COEFF_MSB]}}, c};
    endfunction

endpackage

// *** src/tap_set_assembler.sv ***
// One nine-tap coefficient set, registered, for one filter instance.
// Assumes edge taps arrive in tap order with the center tap apart.
`timescale 1ns/1ps
module tap_set_assembler
    import fir_coeff_pkg::*;
(
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           enable,
    input  wire coeff_type      edge_taps [EDGE_TAPS],
    input  wire wide_coeff_type center_tap,
    output wide_coeff_type      taps      [NUM_TAPS]
);

    // ****************************************************************
    // Set assembly; an unused filter sees all-zero taps
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_TAPS; i++) begin
                taps[i] <= WIDE_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_TAPS; i++) begin
                if (!enable) begin
                    taps[i] <= WIDE_RESET;
                end else if (i < CENTER_TAP) begin
                    taps[i] <= widen(edge_taps[i]);
                end else if (i == CENTER_TAP) begin
                    taps[i] <= center_tap;
                end else begin
                    taps[i] <= widen(edge_taps[i-1]);
                end
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_center_full_width: assert property (
        enable |=> taps[CENTER_TAP] == $past(center_tap))
        else $error("center tap not passed at full width");

    a_idle_set_zero: assert property (
        !enable |=> (taps[0] == WIDE_RESET) && (taps[NUM_TAPS-1] == WIDE_RESET))
        else $error("disabled tap set not cleared");

endmodule

// *** src/fir_coefficient_bank.sv ***
// Tap coefficient bank on AHB-Lite: channel A taps 6-9, channel B taps 1-2.
// Assumes zero-wait single word transfers and a mode level on hclk.
//
// Operation
// - Each tap holds a 12-bit two's complement coefficient in bits 11:0.
// - All tap registers reset to zero; reserved bits 15:12 stay read/write.
// - Readback always returns coefficient bit 11 as zero.
// - Channel A registers feed taps six to nine in dual-channel mode.
// - In single-channel mode those registers feed the single filter instead.
// - Channel B registers feed taps one and two, dual-channel mode only.
// - Each register is a four-byte word slot at its own address.
// - Nine-tap filter whose central fifth tap is 18 bits wide.
`timescale 1ns/1ps
module fir_coefficient_bank
    import fir_coeff_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [ADDR_WIDTH-1:0] haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  dual_channel_mode,
    input  wire coeff_type             chan_a_lead_taps        [4],
    input  wire wide_coeff_type        chan_a_center_tap_coeff,
    input  wire coeff_type             chan_b_mid_taps         [2],
    input  wire wide_coeff_type        chan_b_center_tap_coeff,
    input  wire coeff_type             chan_b_tail_taps        [4],
    output wide_coeff_type             chan_a_taps             [NUM_TAPS],
    output wide_coeff_type             single_taps             [NUM_TAPS],
    output wide_coeff_type             chan_b_taps             [NUM_TAPS]
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Returns {hit, slot}; only word-aligned addresses hit
    function automatic logic [3:0] decode_slot(input logic [ADDR_WIDTH-1:0] addr);
        logic [3:0] r;
        r = 4'h0;
        if (addr[1:0] == 2'h0) begin
            case (addr[ADDR_WIDTH-1:2])
                IDX_CHAN_A_TAP6: r = {1'b1, SLOT_CHAN_A_TAP6};
                IDX_CHAN_A_TAP7: r = {1'b1, SLOT_CHAN_A_TAP7};
                IDX_CHAN_A_TAP8: r = {1'b1, SLOT_CHAN_A_TAP8};
                IDX_CHAN_A_TAP9: r = {1'b1, SLOT_CHAN_A_TAP9};
                IDX_CHAN_B_TAP1: r = {1'b1, SLOT_CHAN_B_TAP1};
                IDX_CHAN_B_TAP2: r = {1'b1, SLOT_CHAN_B_TAP2};
                default:         r = 4'h0;
            endcase
        end
        decode_slot = r;
    endfunction

    // Readback view: coefficient top bit never comes back
    function automatic logic [REG_WIDTH-1:0] readback_view(input logic [REG_WIDTH-1:0] v);
        readback_view = {v[REG_WIDTH-1:RESV_LSB], 1'b0, v[COEFF_MSB-1:0]};
    endfunction

    // ****************************************************************
    // Address phase capture
    // ****************************************************************
    logic [REG_WIDTH-1:0] tap_store [NUM_REGS];
    logic [3:0]           addr_dec;
    logic                 take_phase;
    logic                 wr_pend;
    logic [2:0]           wr_slot;
    logic [REG_WIDTH-1:0] fwd_value;
    logic [REG_WIDTH-1:0] next_rdata;

    assign addr_dec   = decode_slot(haddr);
    assign take_phase = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_slot <= 3'h0;
        end else if (hready) begin
            wr_pend <= take_phase && hwrite && addr_dec[3];
            wr_slot <= addr_dec[2:0];
        end
    end

    // ****************************************************************
    // Coefficient storage
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                tap_store[i] <= TAP_RESET;
            end
        end else if (wr_pend) begin
            tap_store[wr_slot] <= hwdata[REG_WIDTH-1:0];
        end
    end

    // ****************************************************************
    // Read data; a write finishing this cycle is forwarded
    // ****************************************************************
    always_comb begin
        fwd_value = tap_store[addr_dec[2:0]];
        if (wr_pend && (wr_slot == addr_dec[2:0])) begin
            fwd_value = hwdata[REG_WIDTH-1:0];
        end
        next_rdata = addr_dec[3] ? readback_view(fwd_value) : TAP_RESET;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take_phase && !hwrite) begin
            hrdata <= {16'h0000, next_rdata};
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    // ****************************************************************
    // Routing to the filters
    // ****************************************************************
    coeff_type chan_a_edge [EDGE_TAPS];
    coeff_type chan_b_edge [EDGE_TAPS];
    logic      single_mode;

    assign single_mode = !dual_channel_mode;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chan_a_edge[i]   = chan_a_lead_taps[i];
            chan_a_edge[i+4] = tap_store[i][COEFF_WIDTH-1:0];
            chan_b_edge[i+4] = chan_b_tail_taps[i];
        end
        chan_b_edge[0] = tap_store[SLOT_CHAN_B_TAP1][COEFF_WIDTH-1:0];
        chan_b_edge[1] = tap_store[SLOT_CHAN_B_TAP2][COEFF_WIDTH-1:0];
        chan_b_edge[2] = chan_b_mid_taps[0];
        chan_b_edge[3] = chan_b_mid_taps[1];
    end

    tap_set_assembler chan_a_set (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .enable     (dual_channel_mode),
        .edge_taps  (chan_a_edge),
        .center_tap (chan_a_center_tap_coeff),
        .taps       (chan_a_taps)
    );

    // Single filter shares the channel A registers
    tap_set_assembler single_set (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .enable     (single_mode),
        .edge_taps  (chan_a_edge),
        .center_tap (chan_a_center_tap_coeff),
        .taps       (single_taps)
    );

    tap_set_assembler chan_b_set (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .enable     (dual_channel_mode),
        .edge_taps  (chan_b_edge),
        .center_tap (chan_b_center_tap_coeff),
        .taps       (chan_b_taps)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [REG_WIDTH-1:0] tap6_value;
    logic [REG_WIDTH-1:0] tap9_value;
    logic [REG_WIDTH-1:0] b_tap1_value;
    logic [REG_WIDTH-1:0] b_tap2_value;
    logic [REG_WIDTH-1:0] slot_value;
    wide_coeff_type       tap6_wide;
    wide_coeff_type       tap9_wide;
    wide_coeff_type       b_tap1_wide;
    wide_coeff_type       tap7_wide;
    wide_coeff_type       tap8_wide;
    wide_coeff_type       b_tap2_wide;

    assign tap6_value   = tap_store[SLOT_CHAN_A_TAP6];
    assign tap9_value   = tap_store[SLOT_CHAN_A_TAP9];
    assign b_tap1_value = tap_store[SLOT_CHAN_B_TAP1];
    assign b_tap2_value = tap_store[SLOT_CHAN_B_TAP2];
    assign slot_value   = tap_store[wr_slot];
    assign tap6_wide    = widen(tap6_value[COEFF_WIDTH-1:0]);
    assign tap9_wide    = widen(tap9_value[COEFF_WIDTH-1:0]);
    assign b_tap1_wide  = widen(b_tap1_value[COEFF_WIDTH-1:0]);
    assign tap7_wide    = widen(tap_store[SLOT_CHAN_A_TAP7][COEFF_WIDTH-1:0]);
    assign tap8_wide    = widen(tap_store[SLOT_CHAN_A_TAP8][COEFF_WIDTH-1:0]);
    assign b_tap2_wide  = widen(b_tap2_value[COEFF_WIDTH-1:0]);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence write_tap6_req;
        take_phase && hwrite && (haddr == {IDX_CHAN_A_TAP6, 2'h0});
    endsequence

    sequence read_tap6_req;
        take_phase && !hwrite && (haddr == {IDX_CHAN_A_TAP6, 2'h0});
    endsequence

    a_read_msb_zero: assert property (
        read_tap6_req |=> (hrdata[COEFF_MSB] == 1'b0) && (hrdata[31:16] == 16'h0000))
        else $error("readback returned coefficient top bit or upper half");

    a_write_then_read: assert property (
        write_tap6_req ##2 read_tap6_req |=>
            hrdata[REG_WIDTH-1:0] == readback_view($past(hwdata[REG_WIDTH-1:0], 2)))
        else $error("back-to-back readback mismatch");

    a_write_stores: assert property (
        wr_pend |=> slot_value == $past(hwdata[REG_WIDTH-1:0]))
        else $error("write data not stored");

    a_reserved_kept: assert property (
        write_tap6_req ##1 1'b1 |=>
            tap6_value[REG_WIDTH-1:RESV_LSB] == $past(hwdata[REG_WIDTH-1:RESV_LSB]))
        else $error("reserved bits not writable");

    a_reset_clear: assert property (
        $rose(hresetn) |-> (tap6_value == TAP_RESET) && (tap9_value == TAP_RESET)
            && (b_tap1_value == TAP_RESET) && (b_tap2_value == TAP_RESET))
        else $error("taps not zero after reset");

    a_unmapped_zero: assert property (
        take_phase && !hwrite && !addr_dec[3] |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_dual_a_route: assert property (
        dual_channel_mode |=> (chan_a_taps[5] == $past(tap6_wide))
            && (chan_a_taps[8] == $past(tap9_wide)) && (single_taps[5] == WIDE_RESET))
        else $error("channel A taps not routed in dual mode");

    a_single_route: assert property (
        single_mode |=> (single_taps[5] == $past(tap6_wide))
            && (single_taps[8] == $past(tap9_wide)) && (chan_a_taps[5] == WIDE_RESET))
        else $error("single filter taps not routed");

    a_chan_b_gate: assert property (
        dual_channel_mode |=> chan_b_taps[0] == $past(b_tap1_wide)
        ) else $error("channel B tap one not routed");

    a_chan_b_idle: assert property (
        single_mode |=> chan_b_taps[1] == WIDE_RESET)
        else $error("channel B active in single mode");

    a_dual_mid_route: assert property (
        dual_channel_mode |=> (chan_a_taps[6] == $past(tap7_wide))
            && (chan_a_taps[7] == $past(tap8_wide)))
        else $error("channel A middle taps not routed");

    a_single_mid_route: assert property (
        single_mode |=> (single_taps[6] == $past(tap7_wide))
            && (single_taps[7] == $past(tap8_wide)))
        else $error("single filter middle taps not routed");

    a_chan_b_tap2: assert property (
        dual_channel_mode |=> chan_b_taps[1] == $past(b_tap2_wide))
        else $error("channel B tap two not routed");

    a_coeff_signed: assert property (
        dual_channel_mode && tap6_value[COEFF_MSB] |=> chan_a_taps[5][CENTER_WIDTH-1])
        else $error("negative coefficient lost its sign");

    a_center_b_wide: assert property (
        dual_channel_mode |=> chan_b_taps[CENTER_TAP] == $past(chan_b_center_tap_coeff))
        else $error("channel B center tap not passed at full width");

    a_hole_no_write: assert property (
        take_phase && hwrite && !addr_dec[3] |=> !wr_pend)
        else $error("write to unmapped address accepted");

    a_read_returns_idle: assert property (
        hready && !(take_phase && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data held beyond data phase");

    a_reserved_read: assert property (
        take_phase && !hwrite && !wr_pend && (haddr == {IDX_CHAN_A_TAP6, 2'h0}) |=>
            hrdata[REG_WIDTH-1:RESV_LSB] == $past(tap6_value[REG_WIDTH-1:RESV_LSB]))
        else $error("reserved bits not read back");

    a_low_bits_read: assert property (
        take_phase && !hwrite && !wr_pend && (haddr == {IDX_CHAN_A_TAP6, 2'h0}) |=>
            hrdata[COEFF_MSB-1:0] == $past(tap6_value[COEFF_MSB-1:0]))
        else $error("coefficient low bits not read back");

    a_mode_exclusive: assert property (
        (chan_a_taps[5] == WIDE_RESET) || (single_taps[5] == WIDE_RESET))
        else $error("both channel A and single filter active");

    a_always_okay: assert property (
        hreadyout && (hresp == HRESP_OKAY))
        else $error("slave stalled or errored");

endmodule

// *** verification/fir_coefficient_bank_tb_top.sv ***
// Self-checking bench for the tap coefficient bank over AHB-Lite.
// Assumes one slave on the bus, so hready is hreadyout looped back.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin exp_v = (e); tests_run++; if ((g) !== exp_v) begin errors++; $display("BAD %s exp %h got %h", nm, exp_v, (g)); end end
module fir_coefficient_bank_tb_top
    import fir_coeff_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic                  hclk;
    logic                  hresetn;
    logic                  hsel;
    logic [ADDR_WIDTH-1:0] haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [31:0]           hwdata;
    wire  logic            hready;
    logic                  hreadyout;
    logic                  hresp;
    logic [31:0]           hrdata;
    logic                  mode;
    coeff_type             lead       [4];
    wide_coeff_type        center_a;
    coeff_type             mid        [2];
    wide_coeff_type        center_b;
    coeff_type             tail       [4];
    wide_coeff_type        chan_a_taps [NUM_TAPS];
    wide_coeff_type        single_taps [NUM_TAPS];
    wide_coeff_type        chan_b_taps [NUM_TAPS];
    logic [31:0]           q          [$];
    logic [31:0]           exp_v;
    logic [15:0]           model      [6];
    logic [11:0]           idx_tab    [6];
    logic                  rd_pend;
    logic                  probe_req;
    integer                seed = 32'h3f27_00d2;
    int                    errors = 0;
    int                    tests_run = 0;
    int                    cyc = 0;

    assign hready = hreadyout;

    fir_coefficient_bank uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .dual_channel_mode(mode), .chan_a_lead_taps(lead),
        .chan_a_center_tap_coeff(center_a), .chan_b_mid_taps(mid),
        .chan_b_center_tap_coeff(center_b), .chan_b_tail_taps(tail),
        .chan_a_taps(chan_a_taps), .single_taps(single_taps), .chan_b_taps(chan_b_taps)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [17:0] sx(input coeff_type v);
        return {{6{v[11]}}, v};
    endfunction

    function automatic int slot_of(input logic [11:0] idx);
        for (int i = 0; i < 6; i++) begin
            if (idx_tab[i] === idx) return i;
        end
        return -1;
    endfunction

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One single AHB-Lite transfer, waits on hready in both phases
    task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        int s;
        s = slot_of(idx);
        if (s >= 0) model[s] = d[15:0];
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] idx);
        int s;
        s = slot_of(idx);
        q.push_back(s < 0 ? 32'h0000_0000 : {16'h0000, model[s] & 16'hf7ff});
        bus(idx, 1'b0, $random(seed));
    endtask

    task automatic shake_inputs();
        for (int i = 0; i < 4; i++) lead[i] <= coeff_type'($random(seed));
        for (int i = 0; i < 4; i++) tail[i] <= coeff_type'($random(seed));
        for (int i = 0; i < 2; i++) mid[i] <= coeff_type'($random(seed));
        center_a <= wide_coeff_type'($random(seed));
        center_b <= wide_coeff_type'($random(seed));
    endtask

    // Notes the expected tap sets after outputs have settled
    task automatic probe();
        logic [17:0] a [9];
        logic [17:0] b [9];
        repeat (3) @(posedge hclk);
        for (int i = 0; i < 4; i++) a[i] = sx(lead[i]);
        a[4] = center_a;
        for (int i = 0; i < 4; i++) a[5+i] = sx(model[i][11:0]);
        b[0] = sx(model[4][11:0]);
        b[1] = sx(model[5][11:0]);
        for (int i = 0; i < 2; i++) b[2+i] = sx(mid[i]);
        b[4] = center_b;
        for (int i = 0; i < 4; i++) b[5+i] = sx(tail[i]);
        for (int i = 0; i < 9; i++) begin
            q.push_back(mode ? {14'h0000, a[i]} : 32'h0000_0000);
            q.push_back(mode ? 32'h0000_0000 : {14'h0000, a[i]});
            q.push_back(mode ? {14'h0000, b[i]} : 32'h0000_0000);
        end
        probe_req <= 1'b1;
        @(posedge hclk);
        probe_req <= 1'b0;
    endtask

    // ****************************************************************
    // Output watcher
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend <= 1'b0;
        end else begin
            if (rd_pend) begin
                `CHK("hrdata", q.pop_front(), hrdata)
                `CHK("hresp", 32'h0000_0000, {31'h0, hresp})
                `CHK("hreadyout", 32'h0000_0001, {31'h0, hreadyout})
            end
            if (probe_req) begin
                for (int i = 0; i < 9; i++) begin
                    `CHK("chan_a_taps", q.pop_front(), {14'h0, chan_a_taps[i]})
                    `CHK("single_taps", q.pop_front(), {14'h0, single_taps[i]})
                    `CHK("chan_b_taps", q.pop_front(), {14'h0, chan_b_taps[i]})
                end
            end
            rd_pend <= hsel && htrans[1] && !hwrite && hready;
        end
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] wv;
        int          s;
        idx_tab = '{IDX_CHAN_A_TAP6, IDX_CHAN_A_TAP7, IDX_CHAN_A_TAP8, IDX_CHAN_A_TAP9,
                    IDX_CHAN_B_TAP1, IDX_CHAN_B_TAP2};
        for (int i = 0; i < 6; i++) model[i] = TAP_RESET;
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = HTRANS_IDLE;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000; mode = 1'b1;
        probe_req = 1'b0;
        for (int i = 0; i < 4; i++) begin lead[i] = '0; tail[i] = '0; end
        mid[0] = '0; mid[1] = '0; center_a = '0; center_b = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        shake_inputs();
        // Reset contents, then taps with registers still at zero
        for (int i = 0; i < 6; i++) rd(idx_tab[i]);
        probe();
        // Write with bit 11 set and random reserved bits, read straight back
        for (int i = 0; i < 6; i++) begin
            wv = $random(seed);
            wv[11] = 1'b1;
            wr(idx_tab[i], wv);
            rd(idx_tab[i]);
        end
        // Holes between taps take no data and read zero
        wr(12'h424, 32'hffff_ffff);
        wr(12'h449, 32'hffff_ffff);
        rd(12'h424);
        rd(12'h449);
        rd(12'h423);
        rd(12'h44a);
        // Both modes, then a random mix
        for (int m = 0; m < 2; m++) begin
            mode <= m[0];
            shake_inputs();
            probe();
        end
        repeat (30) begin
            s = $unsigned($random(seed)) % 6;
            wr(idx_tab[s], $random(seed));
            s = $unsigned($random(seed)) % 6;
            rd(idx_tab[s]);
            mode <= 1'($random(seed));
            shake_inputs();
            probe();
        end
        repeat (4) @(posedge hclk);
        close_out();
    end
endmodule
